// File: logic/pcs_counter.sv
`timescale 1ns/1ps
module pcs_counter #(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic inc,
  input wire logic clr,
  input wire logic wrap_en,
  output logic [W-1:0] value,
  output logic hit_max
);

  logic at_max;

  // Increment arriving on an all-ones value
  assign at_max = &value;
  assign hit_max = inc & ~clr & at_max;

  // Clear keeps an event of the same cycle, so no count is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value <= '0;
    end else if (clr) begin
      value <= {{(W-1){1'b0}}, inc};
    end else if (inc && at_max) begin
      value <= wrap_en ? '0 : value;
    end else if (inc) begin
      value <= value + 1'b1;
    end
  end

  a_count_step: assert property (@(posedge pclk) disable iff (!presetn) // [RQ17]
    inc && !clr && !at_max |=> value == $past(value) + 1'b1)
    else $error("counter did not step by one");

  a_single_stop: assert property (@(posedge pclk) disable iff (!presetn) // [RQ15]
    inc && !clr && at_max && !wrap_en |=> &value)
    else $error("single mode counter left its maximum");

endmodule

// File: logic/pcs_pkg.sv
// What this block does
// RQ1: A 16-bit count of checker bytes is kept and, in single mode, stops at all ones.
// RQ2: Writing one to bit 0 of the checker status register freezes a snapshot of all counters.
// RQ3: Writing one to bit 1 of that register snapshots all counters and then clears them.
// RQ4: A 32-bit checker packet count is kept, low half in one register and high half in the next.
// RQ5: In single mode each 32-bit packet counter stops once it reaches all ones.
// RQ6: A 32-bit count of errored packets is kept, readable as two consecutive halves.
// RQ7: Errored bits are counted in an 8-bit field of the status register, stopping in single mode.
// RQ8: Bit error counter wraps are counted in a saturating 8-bit counter, idle in single mode.
// RQ9: A packet counter overflow flag at bit 10 stays set until a clear through bit 1.
// RQ10: A byte counter overflow flag at bit 9 stays set until a clear through bit 1.
// RQ11: Bit 8 reads one while the checker is locked to the received stream.
// RQ12: A sticky sync-loss flag at bit 13 records loss of lock and is cleared by writing zero.
// RQ13: A done flag at bit 12 is set once the generator has sent every requested packet.
// RQ14: A busy flag at bit 11 reads one while the packet generator runs.
// RQ15: Count mode picks continuous (wrap to zero with a pulse) or single (stop at maximum).
// RQ16: The send request bit clears itself when the generator done flag becomes set.
// RQ17: Live counters keep counting while reads return the values of the latest snapshot.
package pcs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] PCS_IDX_CONFIG = 10'h119;
  localparam logic [9:0] PCS_IDX_BYTE_TOTAL = 10'h11C;
  localparam logic [9:0] PCS_IDX_PKT_LOW = 10'h11D;
  localparam logic [9:0] PCS_IDX_PKT_HIGH = 10'h11E;
  localparam logic [9:0] PCS_IDX_FLAGS = 10'h11F;
  localparam logic [9:0] PCS_IDX_WRAP_TOTAL = 10'h120;
  localparam logic [9:0] PCS_IDX_ERR_PKT_LOW = 10'h121;
  localparam logic [9:0] PCS_IDX_ERR_PKT_HIGH = 10'h122;

  // Field positions in the flags register
  localparam int PCS_BIT_SNAP = 0;
  localparam int PCS_BIT_SNAP_CLEAR = 1;
  localparam int PCS_BIT_LOCK = 8;
  localparam int PCS_BIT_BYTE_OV = 9;
  localparam int PCS_BIT_PKT_OV = 10;
  localparam int PCS_BIT_BUSY = 11;
  localparam int PCS_BIT_DONE = 12;
  localparam int PCS_BIT_SYNC_LOSS = 13;

  // Field positions in the configuration register
  localparam int PCS_BIT_CNT_MODE = 3;
  localparam int PCS_BIT_SEND = 12;

  // Counter widths and reset values
  localparam int PCS_BYTE_W = 16;
  localparam int PCS_PKT_W = 32;
  localparam int PCS_BITERR_W = 8;
  localparam logic PCS_RST_CNT_MODE = 1'b0;
  localparam logic PCS_RST_SEND = 1'b0;
  localparam logic [15:0] PCS_RST_DATA = 16'h0000;

  // Per-cycle events from the checker datapath
  typedef struct packed {
    logic byte_rx;
    logic pkt_rx;
    logic pkt_err;
    logic bit_err;
    logic lock;
  } pcs_chk_evt_t;

  // Generator state
  typedef struct packed {
    logic busy;
    logic all_sent;
  } pcs_gen_stat_t;

endpackage

// File: logic/pcs_status_bank.sv
`timescale 1ns/1ps
module pcs_status_bank (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pcs_pkg::pcs_chk_evt_t chk,
  input wire pcs_pkg::pcs_gen_stat_t gen,
  output logic send_req,
  output logic count_continuous
);
  import pcs_pkg::*;

  logic [9:0] idx;
  logic wr_fire;
  logic wr_flags;
  logic wr_config;
  logic snap;
  logic clear;
  logic lock_q;
  logic busy_q;
  logic byte_ov;
  logic pkt_ov;
  logic sync_loss;
  logic done;
  logic done_set;
  logic byte_hit;
  logic pkt_hit;
  logic bit_hit;
  logic [PCS_BYTE_W-1:0] live_byte;
  logic [PCS_PKT_W-1:0] live_pkt;
  logic [PCS_PKT_W-1:0] live_err_pkt;
  logic [PCS_BITERR_W-1:0] live_bit_err;
  logic [PCS_BITERR_W-1:0] live_wrap;
  logic [PCS_BYTE_W-1:0] snap_byte;
  logic [PCS_PKT_W-1:0] snap_pkt;
  logic [PCS_PKT_W-1:0] snap_err_pkt;
  logic [PCS_BITERR_W-1:0] snap_bit_err;
  logic [PCS_BITERR_W-1:0] snap_wrap;
  logic [15:0] flags_word;
  logic [15:0] config_word;
  logic [15:0] next_rdata;
  logic next_mapped;

  // Bus decode; writes land only on the completing access edge
  assign idx = paddr[11:2];
  assign wr_fire = psel & penable & pready & pwrite;
  assign wr_flags = wr_fire && (idx == PCS_IDX_FLAGS);
  assign wr_config = wr_fire && (idx == PCS_IDX_CONFIG);
  assign clear = wr_flags & pwdata[PCS_BIT_SNAP_CLEAR]; // [RQ3]
  assign snap = wr_flags & (pwdata[PCS_BIT_SNAP] | pwdata[PCS_BIT_SNAP_CLEAR]); // [RQ2]
  assign done_set = gen.all_sent;

  // Byte total, saturating in single mode
  pcs_counter #(.W(PCS_BYTE_W)) u_byte (
    .pclk(pclk),
    .presetn(presetn),
    .inc(chk.byte_rx), // [RQ1]
    .clr(clear),
    .wrap_en(count_continuous), // [RQ15]
    .value(live_byte),
    .hit_max(byte_hit)
  );

  // Packet total
  pcs_counter #(.W(PCS_PKT_W)) u_pkt (
    .pclk(pclk),
    .presetn(presetn),
    .inc(chk.pkt_rx), // [RQ4]
    .clr(clear),
    .wrap_en(count_continuous), // [RQ5]
    .value(live_pkt),
    .hit_max(pkt_hit)
  );

  // Errored packet total
  pcs_counter #(.W(PCS_PKT_W)) u_err_pkt (
    .pclk(pclk),
    .presetn(presetn),
    .inc(chk.pkt_err), // [RQ6]
    .clr(clear),
    .wrap_en(count_continuous), // [RQ5]
    .value(live_err_pkt),
    .hit_max()
  );

  // Errored bit count
  pcs_counter #(.W(PCS_BITERR_W)) u_bit_err (
    .pclk(pclk),
    .presetn(presetn),
    .inc(chk.bit_err), // [RQ7]
    .clr(clear),
    .wrap_en(count_continuous),
    .value(live_bit_err),
    .hit_max(bit_hit)
  );

  // Wraps of the bit counter; only meaningful when wrapping is allowed
  pcs_counter #(.W(PCS_BITERR_W)) u_wrap (
    .pclk(pclk),
    .presetn(presetn),
    .inc(bit_hit & count_continuous), // [RQ8]
    .clr(clear),
    .wrap_en(1'b0),
    .value(live_wrap),
    .hit_max()
  );

  // Overflow flags live until a counter clear
  pcs_sticky u_byte_ov (
    .pclk(pclk),
    .presetn(presetn),
    .set(byte_hit), // [RQ10]
    .clr(clear),
    .flag(byte_ov)
  );

  pcs_sticky u_pkt_ov (
    .pclk(pclk),
    .presetn(presetn),
    .set(pkt_hit), // [RQ9]
    .clr(clear),
    .flag(pkt_ov)
  );

  // Sync loss: falling lock sets, a zero written to its bit clears
  pcs_sticky u_sync_loss (
    .pclk(pclk),
    .presetn(presetn),
    .set(lock_q & ~chk.lock), // [RQ12]
    .clr(wr_flags & ~pwdata[PCS_BIT_SYNC_LOSS]), // [RQ12]
    .flag(sync_loss)
  );

  // Done: set by the generator, dropped by a fresh send request
  pcs_sticky u_done (
    .pclk(pclk),
    .presetn(presetn),
    .set(done_set), // [RQ13]
    .clr(wr_config & pwdata[PCS_BIT_SEND]),
    .flag(done)
  );

  // Lock and busy follow their sources, one flop late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      lock_q <= chk.lock; // [RQ11]
      busy_q <= gen.busy; // [RQ14]
    end
  end

  // Snapshot copies; taken before any same-cycle clear lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_byte <= '0;
      snap_pkt <= '0;
      snap_err_pkt <= '0;
      snap_bit_err <= '0;
      snap_wrap <= '0;
    end else if (snap) begin
      snap_byte <= live_byte; // [RQ17]
      snap_pkt <= live_pkt;
      snap_err_pkt <= live_err_pkt;
      snap_bit_err <= live_bit_err;
      snap_wrap <= live_wrap;
    end
  end

  // Configuration: mode select and self-clearing send request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_continuous <= PCS_RST_CNT_MODE;
      send_req <= PCS_RST_SEND;
    end else begin
      if (wr_config) begin
        count_continuous <= pwdata[PCS_BIT_CNT_MODE]; // [RQ15]
      end
      // A new request in the done cycle is kept, so it is not dropped
      if (wr_config && pwdata[PCS_BIT_SEND]) begin
        send_req <= 1'b1;
      end else if (done_set) begin
        send_req <= 1'b0; // [RQ16]
      end
    end
  end

  // Readback words
  always_comb begin
    flags_word = PCS_RST_DATA;
    flags_word[PCS_BITERR_W-1:0] = snap_bit_err; // [RQ7]
    flags_word[PCS_BIT_LOCK] = lock_q; // [RQ11]
    flags_word[PCS_BIT_BYTE_OV] = byte_ov; // [RQ10]
    flags_word[PCS_BIT_PKT_OV] = pkt_ov; // [RQ9]
    flags_word[PCS_BIT_BUSY] = busy_q; // [RQ14]
    flags_word[PCS_BIT_DONE] = done; // [RQ13]
    flags_word[PCS_BIT_SYNC_LOSS] = sync_loss; // [RQ12]
    config_word = PCS_RST_DATA;
    config_word[PCS_BIT_CNT_MODE] = count_continuous;
    config_word[PCS_BIT_SEND] = send_req;
  end

  // Read mux; counter reads always see snapshots, never live counters
  always_comb begin
    next_rdata = PCS_RST_DATA;
    next_mapped = 1'b1;
    case (idx)
      PCS_IDX_CONFIG: next_rdata = config_word;
      PCS_IDX_BYTE_TOTAL: next_rdata = snap_byte; // [RQ17]
      PCS_IDX_PKT_LOW: next_rdata = snap_pkt[15:0]; // [RQ4]
      PCS_IDX_PKT_HIGH: next_rdata = snap_pkt[31:16]; // [RQ4]
      PCS_IDX_FLAGS: next_rdata = flags_word;
      PCS_IDX_WRAP_TOTAL: next_rdata = {8'h00, snap_wrap}; // [RQ8]
      PCS_IDX_ERR_PKT_LOW: next_rdata = snap_err_pkt[15:0]; // [RQ6]
      PCS_IDX_ERR_PKT_HIGH: next_rdata = snap_err_pkt[31:16]; // [RQ6]
      default: next_mapped = 1'b0;
    endcase
  end

  // APB answer: one wait-free access cycle, all outputs from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~next_mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= {16'h0000, next_rdata};
      end else begin
        prdata <= '0;
      end
    end
  end

  a_snap_copies: assert property (@(posedge pclk) disable iff (!presetn) // [RQ2]
    snap |=> snap_pkt == $past(live_pkt) && snap_byte == $past(live_byte))
    else $error("snapshot did not capture live counters");

  a_clear_zeroes: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
    clear && !chk.pkt_rx && !chk.byte_rx |=> live_pkt == '0 && live_byte == '0)
    else $error("clear left counters nonzero");

  a_pkt_ov_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
    pkt_ov && !clear |=> pkt_ov)
    else $error("packet overflow flag dropped without clear");

  a_wrap_single: assert property (@(posedge pclk) disable iff (!presetn) // [RQ8]
    !count_continuous && !clear |=> live_wrap == $past(live_wrap))
    else $error("wrap count moved in single mode");

  a_lock_follows: assert property (@(posedge pclk) disable iff (!presetn) // [RQ11]
    chk.lock ##1 chk.lock |-> lock_q)
    else $error("lock bit does not follow checker");

  a_send_clears: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
    done_set && !(wr_config && pwdata[PCS_BIT_SEND]) |=> !send_req && done)
    else $error("send request not cleared on done");

  a_busy_track: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14]
    gen.busy |=> busy_q)
    else $error("busy bit does not follow generator");

  a_held_reads: assert property (@(posedge pclk) disable iff (!presetn) // [RQ17]
    !snap |=> snap_err_pkt == $past(snap_err_pkt) && snap_wrap == $past(snap_wrap))
    else $error("snapshot changed without a request");

  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");

  // Overflow flags: set wins, only the clear strobe drops them
  a_byte_ov_set: assert property (@(posedge pclk) disable iff (!presetn) // [RQ10]
    byte_hit |=> byte_ov)
    else $error("byte overflow flag not set");

  a_byte_ov_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RQ10]
    byte_ov && !clear |=> byte_ov)
    else $error("byte overflow flag dropped without clear");

  a_byte_ov_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RQ10]
    clear && !byte_hit |=> !byte_ov)
    else $error("byte overflow flag survived clear");

  a_pkt_ov_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
    !pkt_ov && !pkt_hit |=> !pkt_ov)
    else $error("packet overflow flag set without overflow");

  a_pkt_ov_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
    clear && !pkt_hit |=> !pkt_ov)
    else $error("packet overflow flag survived clear");

  // Sync loss, done, send request, count mode, wrap and lock checks
  a_sync_set: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
    lock_q && !chk.lock |=> sync_loss)
    else $error("sync loss not recorded");

  a_sync_clear: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
    wr_flags && !pwdata[PCS_BIT_SYNC_LOSS] && !(lock_q && !chk.lock) |=> !sync_loss)
    else $error("sync loss not cleared by zero write");

  a_sync_keep: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
    sync_loss && !(wr_flags && !pwdata[PCS_BIT_SYNC_LOSS]) |=> sync_loss)
    else $error("sync loss dropped without zero write");

  a_done_set: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
    done_set |=> done)
    else $error("done flag not set");

  a_send_sets: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
    wr_config && pwdata[PCS_BIT_SEND] |=> send_req)
    else $error("send request not taken");

  a_mode_write: assert property (@(posedge pclk) disable iff (!presetn) // [RQ15]
    wr_config |=> count_continuous == $past(pwdata[PCS_BIT_CNT_MODE]))
    else $error("count mode not written");

  a_wrap_step: assert property (@(posedge pclk) disable iff (!presetn) // [RQ8]
    bit_hit && count_continuous && !clear && !(&live_wrap)
    |=> live_wrap == $past(live_wrap) + 1'b1)
    else $error("wrap total missed a bit counter wrap");

  a_bit_wraps: assert property (@(posedge pclk) disable iff (!presetn) // [RQ15]
    chk.bit_err && !clear && count_continuous && &live_bit_err |=> live_bit_err == '0)
    else $error("bit counter did not restart from zero");

  a_lock_drop: assert property (@(posedge pclk) disable iff (!presetn) // [RQ11]
    !chk.lock |=> !lock_q)
    else $error("lock bit stayed high");

  // Bus answer contents
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !next_mapped |=> pslverr && prdata == '0)
    else $error("unmapped access not refused");

  a_read_data: assert property (@(posedge pclk) disable iff (!presetn) // [RQ17]
    psel && !penable && !pwrite |=> prdata == {16'h0000, $past(next_rdata)})
    else $error("read data not from the selected register");

  a_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !psel |=> !pready && !pslverr && prdata == '0)
    else $error("bus answer without a request");

endmodule

// File: logic/pcs_sticky.sv
`timescale 1ns/1ps
module pcs_sticky (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set,
  input wire logic clr,
  output logic flag
);

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end

  a_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
    set |=> flag)
    else $error("sticky flag lost a set");

endmodule

// File: verif/pcs_evt_src.sv
`timescale 1ns/1ps
// Far side: checker event pulses and generator status, moved just after edges
module pcs_evt_src (
  input wire logic pclk,
  output pcs_pkg::pcs_chk_evt_t chk,
  output pcs_pkg::pcs_gen_stat_t gen
);
  import pcs_pkg::*;

  initial begin
    chk = '0;
    gen = '0;
  end

  // One pulse a cycle on each selected line (byte, pkt, err pkt, bit err)
  task automatic burst(input int n, input logic [3:0] m);
    repeat (n) begin
      @(posedge pclk);
      chk[4:1] <= m;
    end
    @(posedge pclk);
    chk[4:1] <= 4'h0;
  endtask

  // Levels held until changed again
  task automatic levels(input logic lk, input logic bz);
    @(posedge pclk);
    chk.lock <= lk;
    gen.busy <= bz;
  endtask

  // Finished pulse, a single cycle wide
  task automatic finish_pulse();
    @(posedge pclk);
    gen.all_sent <= 1'b1;
    @(posedge pclk);
    gen.all_sent <= 1'b0;
  endtask
endmodule

// File: verif/pcs_status_bank_tb.sv
`timescale 1ns/1ps
module pcs_status_bank_tb;
  import pcs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rdv;
  logic pready, pslverr, errv, send_req, count_continuous;
  pcs_chk_evt_t chk;
  pcs_gen_stat_t gen;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;

  always #10 pclk = ~pclk;

  pcs_status_bank dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chk(chk), .gen(gen), .send_req(send_req),
    .count_continuous(count_continuous));
  pcs_evt_src src_u (.pclk(pclk), .chk(chk), .gen(gen));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [9:0] idx, input logic [15:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [9:0] idx, input logic [15:0] exp);
    apb(1'b0, idx, 16'h0000);
    check(nm, rdv, {16'h0000, exp});
  endtask

  // Snapshot strobe keeps the sync-loss bit by writing it as one
  task automatic snap();
    apb(1'b1, PCS_IDX_FLAGS, 16'h2001);
  endtask

  task automatic t_reset();
    logic [9:0] ids [8] = '{PCS_IDX_CONFIG, PCS_IDX_BYTE_TOTAL, PCS_IDX_PKT_LOW,
      PCS_IDX_PKT_HIGH, PCS_IDX_FLAGS, PCS_IDX_WRAP_TOTAL, PCS_IDX_ERR_PKT_LOW,
      PCS_IDX_ERR_PKT_HIGH};
    foreach (ids[i]) rd("reset value", ids[i], 16'h0000);
    rd("unmapped data", 10'h3FF, 16'h0000);
    check("unmapped error", {31'h0, errv}, 32'h1);
  endtask

  task automatic t_snap();
    src_u.burst(5, 4'hC);
    src_u.burst(2, 4'h3);
    rd("byte before snap", PCS_IDX_BYTE_TOTAL, 16'h0000);
    snap();
    rd("byte", PCS_IDX_BYTE_TOTAL, 16'h0005);
    rd("pkt low", PCS_IDX_PKT_LOW, 16'h0005);
    rd("pkt high", PCS_IDX_PKT_HIGH, 16'h0000);
    rd("bit errors", PCS_IDX_FLAGS, 16'h0002);
    rd("err pkt low", PCS_IDX_ERR_PKT_LOW, 16'h0002);
    rd("err pkt high", PCS_IDX_ERR_PKT_HIGH, 16'h0000);
    src_u.burst(1, 4'hF);
    rd("byte frozen", PCS_IDX_BYTE_TOTAL, 16'h0005);
    apb(1'b1, PCS_IDX_FLAGS, 16'h2002);
    rd("byte pre-clear", PCS_IDX_BYTE_TOTAL, 16'h0006);
    snap();
    rd("byte cleared", PCS_IDX_BYTE_TOTAL, 16'h0000);
    rd("pkt cleared", PCS_IDX_PKT_LOW, 16'h0000);
  endtask

  task automatic t_sat();
    src_u.burst(260, 4'h1);
    snap();
    rd("bit errors stop", PCS_IDX_FLAGS, 16'h00FF);
    rd("wrap idle single", PCS_IDX_WRAP_TOTAL, 16'h0000);
    src_u.burst(65537, 4'h8);
    snap();
    rd("byte stops", PCS_IDX_BYTE_TOTAL, 16'hFFFF);
    rd("byte overflow", PCS_IDX_FLAGS, 16'h02FF);
    apb(1'b1, PCS_IDX_FLAGS, 16'h2002);
    rd("overflow cleared", PCS_IDX_FLAGS, 16'h00FF);
    apb(1'b1, PCS_IDX_CONFIG, 16'h0008);
    @(negedge pclk);
    check("mode", {31'h0, count_continuous}, 32'h1);
    src_u.burst(256, 4'h1);
    snap();
    rd("bit errors wrap", PCS_IDX_FLAGS, 16'h0000);
    rd("wrap total", PCS_IDX_WRAP_TOTAL, 16'h0001);
  endtask

  task automatic t_status();
    src_u.levels(1'b1, 1'b0);
    repeat (3) @(posedge pclk);
    rd("locked", PCS_IDX_FLAGS, 16'h0100);
    src_u.levels(1'b0, 1'b1);
    repeat (3) @(posedge pclk);
    rd("sync loss busy", PCS_IDX_FLAGS, 16'h2800);
    snap();
    rd("sync loss kept", PCS_IDX_FLAGS, 16'h2800);
    apb(1'b1, PCS_IDX_FLAGS, 16'h0000);
    rd("sync loss cleared", PCS_IDX_FLAGS, 16'h0800);
    apb(1'b1, PCS_IDX_CONFIG, 16'h1008);
    @(negedge pclk);
    check("send set", {31'h0, send_req}, 32'h1);
    rd("config readback", PCS_IDX_CONFIG, 16'h1008);
    src_u.levels(1'b0, 1'b0);
    src_u.finish_pulse();
    repeat (2) @(negedge pclk);
    check("send cleared", {31'h0, send_req}, 32'h0);
    rd("config after done", PCS_IDX_CONFIG, 16'h0008);
    rd("done", PCS_IDX_FLAGS, 16'h1000);
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Hang guard, well above the longest burst
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_snap();
    t_sat();
    t_status();
    give_verdict();
  end
endmodule
